// ==== dv/posc_straps.sv ====
// Board strap resistors and user straps seen on the memory data pins
`default_nettype none
module posc_straps
   import posc_pkg::*;
(
   input wire logic [POSC_PIN_W-1:0] user_level,
   output logic [POSC_PIN_W-1:0] memory_data_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Reserved straps carry fixed resistors, so the bench cannot move them
   localparam logic [POSC_PIN_W-1:0] PULL_MASK = 41'h00078FD0C00;
   // Those of the reserved straps that are pulled up
   localparam logic [POSC_PIN_W-1:0] PULL_UP = 41'h00000FD0000;
   // User straps follow the bench, reserved ones follow their resistor
   assign memory_data_pins = (user_level & ~PULL_MASK) | PULL_UP;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the power-on strap capture block
`default_nettype none
module testbench
   import posc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk;
   logic rst;
   logic [POSC_PIN_W-1:0] user_level;
   logic [POSC_PIN_W-1:0] memory_data_pins;
   posc_io_req_s io_req;
   logic [7:0] io_rdata;
   logic io_rvalid;
   posc_clk_cfg_s clk_cfg;
   logic straps_valid;
   int fails;
   int n_checks;
   logic [31:0] rng;
   // Hand-picked straps: all low, all high, divide by 3, divide by 2
   logic [40:0] corner [4] = '{41'h0, 41'h1FFFFFFFFFF, 41'h10000000050, 41'h00007020090};

   posc_straps board (.user_level(user_level), .memory_data_pins(memory_data_pins));
   posc_top dut (.mclk(mclk), .rst(rst), .memory_data_pins(memory_data_pins),
      .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .clk_cfg(clk_cfg), .straps_valid(straps_valid));

   // Repeatable pseudo-random source
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Clock settings the straps should produce
   function automatic posc_clk_cfg_s exp_cfg(input logic [40:0] p);
      posc_clk_cfg_s c;
      c.pll_range = p[7:6];
      c.pll_reserved = p[7];
      c.out_div = !p[4] ? POSC_DIV4 : (p[17] ? POSC_DIV2 : POSC_DIV3);
      c.mem_host_sync = p[5];
      c.cpu_mult_x2 = p[40];
      c.host_synth = {p[3], p[2], p[26], p[25], p[24]};
      return c;
   endfunction

   // One comparison, counted and reported
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Write strobe; held until the next request or an explicit idle
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk);
      #5;
   endtask

   // Read strobe, held like a write; answer stands in the next cycle
   task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
      io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge mclk);
      #5;
      chk("read valid", 16'h1, {15'h0, io_rvalid});
      chk("read data", {8'h0, exp}, {8'h0, io_rdata});
   endtask

   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Free-running 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Reset, capture and register traffic, corners first then random
   initial begin
      int n;
      logic [40:0] p;
      logic [7:0] idx;
      logic [7:0] r0;
      posc_clk_cfg_s e;
      io_req = '0;
      fails = 0;
      n_checks = 0;
      rng = 32'h000167B6;
      for (int t = 0; t < 12; t++) begin
         rng = xs(rng);
         p[31:0] = rng;
         rng = xs(rng);
         p[40:32] = rng[8:0];
         idx = rng[23:16];
         // Any index but the strap register's
         if (idx == POSC_IDX_POWER_ON_STRAP_CONFIG_0) begin
            idx = 8'h4B;
         end
         if (t < 4) begin
            p = corner[t];
         end
         rst = 1'b1;
         user_level = p;
         repeat (5) @(posedge mclk);
         #5;
         chk("valid in reset", 16'h0, {15'h0, straps_valid});
         chk("cfg in reset", 16'h0, {4'h0, clk_cfg});
         rst = 1'b0;
         n = 0;
         // Capture lands on the third edge after release
         while (straps_valid !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #5 n++;
         end
         chk("capture edge", 16'h3, 16'(n));
         if (n == 8) begin
            close_out();
         end
         e = exp_cfg(memory_data_pins);
         r0 = {memory_data_pins[7:2], POSC_R0_RSV_VALUE};
         chk("pll range", {13'h0, e[11:9]}, {13'h0, clk_cfg[11:9]});
         chk("out divisor", {14'h0, e.out_div}, {14'h0, clk_cfg.out_div});
         chk("sync and mult", {14'h0, e[6:5]}, {14'h0, clk_cfg[6:5]});
         chk("host synth", {11'h0, e.host_synth}, {11'h0, clk_cfg.host_synth});
         io_wr(POSC_IO_INDEX_PORT, POSC_IDX_POWER_ON_STRAP_CONFIG_0);
         io_rd(POSC_IO_DATA_PORT, r0);
         io_wr(POSC_IO_DATA_PORT, ~r0);
         io_rd(POSC_IO_DATA_PORT, r0);
         io_rd(POSC_IO_INDEX_PORT, POSC_IDX_POWER_ON_STRAP_CONFIG_0);
         io_wr(16'h0024, 8'h4A);
         io_rd(16'h0024, POSC_UNMAPPED_READ);
         // Index write read straight back on the next edge
         io_wr(POSC_IO_INDEX_PORT, idx);
         io_rd(POSC_IO_INDEX_PORT, idx);
         io_rd(POSC_IO_DATA_PORT, POSC_UNMAPPED_READ);
         // Bus idle while the straps move
         io_req = '0;
         // Straps moving after capture must change nothing
         user_level = ~p;
         repeat (4) @(posedge mclk);
         #5;
         io_wr(POSC_IO_INDEX_PORT, POSC_IDX_POWER_ON_STRAP_CONFIG_0);
         io_rd(POSC_IO_DATA_PORT, r0);
         chk("cfg held", {4'h0, e}, {4'h0, clk_cfg});
         // Drop the read strobe before the next reset
         io_req = '0;
         $display("test %0d done", t);
      end
      close_out();
   end
endmodule
`default_nettype wire

// ==== rtl/posc_pkg.sv ====
// Shared constants and types for the power-on strap capture block
`default_nettype none
package posc_pkg;
   // I/O port pair and register index
   localparam logic [15:0] POSC_IO_INDEX_PORT = 16'h0022;
   localparam logic [15:0] POSC_IO_DATA_PORT = 16'h0023;
   localparam logic [7:0] POSC_IDX_POWER_ON_STRAP_CONFIG_0 = 8'h4A;
   localparam logic [7:0] POSC_INDEX_RESET = 8'h00;
   localparam logic [7:0] POSC_UNMAPPED_READ = 8'h00;
   localparam logic [7:0] POSC_RDATA_RESET = 8'h00;
   // Strap pin count and positions on the memory data pins
   localparam int POSC_PIN_W = 41;
   localparam int POSC_PIN_SYNTH_LO = 2;
   localparam int POSC_PIN_SYNTH_HI = 3;
   localparam int POSC_PIN_DIV_A = 4;
   localparam int POSC_PIN_SYNC = 5;
   localparam int POSC_PIN_PLL_LO = 6;
   localparam int POSC_PIN_PLL_HI = 7;
   localparam int POSC_PIN_DIV_B = 17;
   localparam int POSC_PIN_SYNTH_B_LO = 24;
   localparam int POSC_PIN_SYNTH_B_HI = 26;
   localparam int POSC_PIN_CPU_MULT = 40;
   // Config register 0 layout
   localparam int POSC_R0_MIRROR_LO = 2;
   localparam int POSC_R0_MIRROR_HI = 7;
   localparam logic [1:0] POSC_R0_RSV_VALUE = 2'h0;
   // PCI PLL range codes
   localparam logic [1:0] POSC_PLL_16_32 = 2'h0;
   localparam logic [1:0] POSC_PLL_32_64 = 2'h1;
   // Cycles the two-flop synchroniser needs after reset release
   localparam logic [1:0] POSC_SYNC_SETTLE = 2'h2;
   localparam logic [1:0] POSC_CNT_STEP = 2'h1;
   localparam logic [1:0] POSC_CNT_ZERO = 2'h0;

   // Peripheral bus output clock divisor
   typedef enum logic [1:0] {
      POSC_DIV4,
      POSC_DIV3,
      POSC_DIV2
   } posc_div_e;

   // Capture sequencer phases
   typedef enum logic [1:0] {
      POSC_ST_SETTLE,
      POSC_ST_HELD
   } posc_phase_e;

   // Register port request
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } posc_io_req_s;

   // Decoded clock configuration for the clock generation logic
   typedef struct packed {
      logic [1:0] pll_range;
      logic pll_reserved;
      posc_div_e out_div;
      logic mem_host_sync;
      logic cpu_mult_x2;
      logic [4:0] host_synth;
   } posc_clk_cfg_s;
endpackage
`default_nettype wire

// ==== rtl/posc_sync.sv ====
// Two-flop synchroniser for the strap pins
`default_nettype none
module posc_sync
   import posc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [POSC_PIN_W-1:0] pins_async,
   output logic [POSC_PIN_W-1:0] pins_sync
);
   // Both stages in one state word
   typedef struct packed {
      logic [POSC_PIN_W-1:0] stage1;
      logic [POSC_PIN_W-1:0] stage2;
   } posc_sync_s;

   posc_sync_s state_reg; // Registered stages
   posc_sync_s state_next; // Next stages

   // Shift pins through; stage1 feeds only stage2
   always_comb begin
      state_next.stage1 = pins_async;
      state_next.stage2 = state_reg.stage1;
   end

   // Clear both stages in reset so nothing stale is captured
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pins_sync = state_reg.stage2;
endmodule
`default_nettype wire

// ==== rtl/posc_top.sv ====
// Power-on strap capture with index/data register port
`default_nettype none
module posc_top
   import posc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [POSC_PIN_W-1:0] memory_data_pins,
   input wire posc_io_req_s io_req,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   output posc_clk_cfg_s clk_cfg,
   output logic straps_valid
);
   // Divisor decode from the two divisor straps
   function automatic posc_div_e div_decode(input logic strap_a, input logic strap_b);
      if (!strap_a) begin
         div_decode = POSC_DIV4;
      end else if (!strap_b) begin
         div_decode = POSC_DIV3;
      end else begin
         div_decode = POSC_DIV2;
      end
   endfunction

   // Whole module state
   typedef struct packed {
      posc_phase_e phase;
      logic [1:0] settle_cnt;
      logic [7:0] power_on_strap_config_0;
      posc_clk_cfg_s cfg;
      logic [7:0] index;
      logic [7:0] rdata;
      logic rvalid;
   } posc_state_s;

   posc_state_s state_reg; // Registered state
   posc_state_s state_next; // Next state
   logic [POSC_PIN_W-1:0] pins_sync; // Synchronised strap levels
   logic index_hit; // Access to index port
   logic data_hit; // Access to data port

   // Pins are board levels, not on mclk, so synchronise first
   posc_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .pins_async(memory_data_pins),
      .pins_sync(pins_sync)
   );

   // Port decode
   assign index_hit = (io_req.addr == POSC_IO_INDEX_PORT);
   assign data_hit = (io_req.addr == POSC_IO_DATA_PORT);

   // Capture sequencer and register port
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      case (state_reg.phase)
         POSC_ST_SETTLE: begin
            // Wait until the synchroniser carries real pin levels
            if (state_reg.settle_cnt == POSC_SYNC_SETTLE) begin
               state_next.phase = POSC_ST_HELD;
               state_next.power_on_strap_config_0 = {pins_sync[POSC_PIN_PLL_HI:POSC_PIN_SYNTH_LO],
                                    POSC_R0_RSV_VALUE};
               state_next.cfg.pll_range = pins_sync[POSC_PIN_PLL_HI:POSC_PIN_PLL_LO];
               state_next.cfg.pll_reserved = pins_sync[POSC_PIN_PLL_HI];
               state_next.cfg.mem_host_sync = pins_sync[POSC_PIN_SYNC];
               state_next.cfg.out_div = div_decode(pins_sync[POSC_PIN_DIV_A],
                                                   pins_sync[POSC_PIN_DIV_B]);
               state_next.cfg.cpu_mult_x2 = pins_sync[POSC_PIN_CPU_MULT];
               state_next.cfg.host_synth = {pins_sync[POSC_PIN_SYNTH_HI:POSC_PIN_SYNTH_LO],
                  pins_sync[POSC_PIN_SYNTH_B_HI:POSC_PIN_SYNTH_B_LO]};
            end else begin
               state_next.settle_cnt = state_reg.settle_cnt + POSC_CNT_STEP;
            end
         end
         POSC_ST_HELD: begin
            // Captured values frozen until the next reset
            state_next.phase = POSC_ST_HELD;
         end
         default: begin
            state_next.phase = POSC_ST_SETTLE;
         end
      endcase
      // Index write selects the register behind the data port
      if (io_req.wr && index_hit) begin
         state_next.index = io_req.wdata;
      end
      // Data port writes are ignored: the strap mirror is read-only
      if (io_req.rd) begin
         state_next.rvalid = 1'b1;
         if (index_hit) begin
            state_next.rdata = state_reg.index;
         end else if (data_hit && state_reg.index == POSC_IDX_POWER_ON_STRAP_CONFIG_0) begin
            state_next.rdata = state_reg.power_on_strap_config_0;
         end else begin
            state_next.rdata = POSC_UNMAPPED_READ; // Unmapped reads as zero
         end
      end
   end

   // State register, synchronous reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg.phase <= POSC_ST_SETTLE;
         state_reg.settle_cnt <= POSC_CNT_ZERO;
         state_reg.power_on_strap_config_0 <= '0;
         state_reg.cfg <= '0;
         state_reg.index <= POSC_INDEX_RESET;
         state_reg.rdata <= POSC_RDATA_RESET;
         state_reg.rvalid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops, except straps_valid, decoded from the phase
   assign io_rdata = state_reg.rdata;
   assign io_rvalid = state_reg.rvalid;
   assign clk_cfg = state_reg.cfg;
   assign straps_valid = (state_reg.phase == POSC_ST_HELD);

   // Capture lands three edges after release
   capture_time_a: assert property (@(posedge mclk)
      $fell(rst) |-> !straps_valid [*3] ##1 straps_valid)
      else $error("strap capture not at third edge after release");

   // Held values never change while valid
   hold_stable_a: assert property (@(posedge mclk) disable iff (rst)
      straps_valid && $past(straps_valid) |-> $stable(clk_cfg) && $stable(state_reg.power_on_strap_config_0))
      else $error("captured straps changed while held");

   // Mirror matches the pins seen by the synchroniser
   mirror_bits_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(straps_valid) |-> state_reg.power_on_strap_config_0 ==
         {$past(pins_sync[POSC_PIN_PLL_HI:POSC_PIN_SYNTH_LO]), POSC_R0_RSV_VALUE})
      else $error("strap register 0 mismatch");

   // Reading the data port at index 4Ah returns register 0
   data_read_a: assert property (@(posedge mclk) disable iff (rst)
      io_req.rd && data_hit && state_reg.index == POSC_IDX_POWER_ON_STRAP_CONFIG_0 && straps_valid
      |=> io_rvalid && io_rdata == $past(state_reg.power_on_strap_config_0))
      else $error("data port read wrong");

   // Index write is read back through the index port
   index_back_a: assert property (@(posedge mclk) disable iff (rst)
      io_req.wr && index_hit ##1 io_req.rd && index_hit && !io_req.wr
      |=> io_rdata == $past(io_req.wdata, 2))
      else $error("index readback wrong");

   // Range field and reserved flag tie to register bits 7..6
   pll_field_a: assert property (@(posedge mclk) disable iff (rst)
      straps_valid |-> clk_cfg.pll_range == state_reg.power_on_strap_config_0[POSC_R0_MIRROR_HI -: 2]
         && clk_cfg.pll_reserved == clk_cfg.pll_range[1])
      else $error("pll range decode wrong");

   // Sync strap equals register bit 5
   sync_bit_a: assert property (@(posedge mclk) disable iff (rst)
      straps_valid |-> clk_cfg.mem_host_sync == state_reg.power_on_strap_config_0[POSC_PIN_SYNC])
      else $error("clock sync strap wrong");

   // Divisor follows strap 4 and pin 17
   divisor_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(straps_valid) |-> clk_cfg.out_div ==
         (!$past(pins_sync[POSC_PIN_DIV_A]) ? POSC_DIV4 :
          ($past(pins_sync[POSC_PIN_DIV_B]) ? POSC_DIV2 : POSC_DIV3)))
      else $error("output clock divisor wrong");

   // Multiplier from its pin, synthesizer code bits 4..3 from register bits 3..2
   mult_synth_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(straps_valid) |-> clk_cfg.cpu_mult_x2 == $past(pins_sync[POSC_PIN_CPU_MULT])
         && clk_cfg.host_synth[4:3] == state_reg.power_on_strap_config_0[POSC_PIN_SYNTH_HI:POSC_PIN_SYNTH_LO])
      else $error("multiplier or synthesizer code wrong");
endmodule
`default_nettype wire
